// ### verilog/charge_cycle_map.vh
// Constants for the charge cycle sequencer: APB offsets, the control reset value and timing counts.
`ifndef CHARGE_CYCLE_MAP_VH
`define CHARGE_CYCLE_MAP_VH
`define CLK_PERIOD_PS 8000
`define DEAD_TIME_PS 30000
`define DEAD_CYCLES ((`DEAD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REFRESH_PS 80000
`define REFRESH_CYCLES (`REFRESH_PS / `CLK_PERIOD_PS)
`define PWM_PERIOD_CYCLES 104
`define DUTY_MAX_PERMILLE 995
`define DUTY_MAX_CYCLES ((`PWM_PERIOD_CYCLES * `DUTY_MAX_PERMILLE) / 1000)
`define BOOT_LOW_CYCLES 3
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * 125)
`define SOFT_STEP_US 1600
`define SOFT_STEP_TICKS (`SOFT_STEP_US / `TICK_US)
`define SOFT_STEPS 8
`define STARTUP_MS 30
`define STARTUP_TICKS (`STARTUP_MS * 1000 / `TICK_US)
`define PRE_TIMEOUT_MIN 30
`define PRE_TIMEOUT_TICKS (`PRE_TIMEOUT_MIN * 60 * 10000)
`define FAST_TIMEOUT_HR 5
`define FAST_TIMEOUT_TICKS (`FAST_TIMEOUT_HR * 3600 * 10000)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DUTY 8'h08
`define REG_SETPOINT 8'h0C
`define CTRL_RESET 32'h00000000
`endif

// ### verilog/gate_drive.v
// Gate drive: PWM, dead time, duty limit, bootstrap refresh and diode emulation.
`timescale 1ns/1ps
`default_nettype none
`include "charge_cycle_map.vh"
module gate_drive (
  input wire sys_clk,
  input wire resetn,
  input wire run,
  input wire [6:0] duty,
  input wire sync_mode,
  input wire boot_low,
  output reg high_drive,
  output reg low_drive
);
  reg [6:0] phase;
  reg [6:0] dead_cnt;
  reg [6:0] pulse_cnt;
  reg [1:0] boot_cycles;
  reg boot_seen;
  reg pulse_done;
  wire cycle_start;
  wire [6:0] eff_duty;
  wire want_high;
  // Timing counts are cut to the counter width on purpose; all fit in seven bits.
  localparam integer DUTY_CAP_I = `DUTY_MAX_CYCLES;
  localparam integer PERIOD_LAST_I = `PWM_PERIOD_CYCLES - 1;
  localparam integer DEAD_I = `DEAD_CYCLES;
  localparam integer REFRESH_I = `REFRESH_CYCLES;
  localparam [6:0] DUTY_CAP = DUTY_CAP_I[6:0];
  localparam [6:0] PERIOD_LAST = PERIOD_LAST_I[6:0];
  localparam [6:0] DEAD_LOAD = DEAD_I[6:0];
  localparam [6:0] REFRESH_LOAD = REFRESH_I[6:0];
  assign cycle_start = (phase == 7'h00);
  // Full-on requests are clipped to DUTY_CAP so the high side is off in the last phase of every cycle.
  assign eff_duty = (duty > DUTY_CAP) ? DUTY_CAP : duty;
  assign want_high = run && (duty != 7'h00) && (phase < eff_duty) && !(boot_cycles == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  // Switching period counter.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      phase <= 7'h00;
    else if (phase == PERIOD_LAST)
      phase <= 7'h00;
    else
      phase <= phase + 7'h01;
  end
  // Count cycles with a low bootstrap; past three, force a refresh cycle.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_cycles <= 2'h0;
      boot_seen <= 1'b0;
    end
    else if (cycle_start)
    begin
      boot_seen <= 1'b0;
      if (!boot_seen || boot_cycles == 2'h3)
        boot_cycles <= 2'h0;
      else
        boot_cycles <= boot_cycles + 2'h1;
    end
    else if (boot_low)
      boot_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Break-before-make sequencing with a dead time and the short refresh pulse.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_drive <= 1'b0;
      low_drive <= 1'b0;
      dead_cnt <= 7'h00;
      pulse_cnt <= 7'h00;
      pulse_done <= 1'b0;
    end
    else if (!run)
    begin
      high_drive <= 1'b0;
      low_drive <= 1'b0;
      dead_cnt <= 7'h00;
      pulse_cnt <= 7'h00;
      pulse_done <= 1'b0;
    end
    else
    begin
      if (cycle_start)
        pulse_done <= 1'b0;
      if (want_high)
      begin
        low_drive <= 1'b0;
        if (low_drive)
          dead_cnt <= DEAD_LOAD;
        else if (dead_cnt != 7'h00)
          dead_cnt <= dead_cnt - 7'h01;
        else
          high_drive <= 1'b1;
      end
      else
      begin
        high_drive <= 1'b0;
        if (high_drive)
          dead_cnt <= DEAD_LOAD;
        else if (dead_cnt != 7'h00)
          dead_cnt <= dead_cnt - 7'h01;
        else if (sync_mode && duty != 7'h00 && boot_cycles != 2'h3)
          low_drive <= 1'b1;
        else if (pulse_cnt != 7'h00)
        begin
          pulse_cnt <= pulse_cnt - 7'h01;
          if (pulse_cnt == 7'h01)
            low_drive <= 1'b0;
        end
        else if ((boot_low || boot_cycles == 2'h3) && !pulse_done && !low_drive)
        begin
          // The non-synchronous pulse is short so inductor current cannot go negative.
          low_drive <= 1'b1;
          pulse_cnt <= REFRESH_LOAD;
          pulse_done <= 1'b1;
        end
        else if (!sync_mode || duty == 7'h00)
          low_drive <= 1'b0;
      end
    end
  end
endmodule // gate_drive
`default_nettype wire

// ### verilog/charge_cycle_sequencer.v
// Charge cycle sequencer: qualification, precharge, fast charge, timers and APB registers.
// Behaviour
// - Battery below low threshold at start enters precharge at reduced current.
// - Precharge over 30 minutes turns charger off and flags a fault.
// - Precharge target is one tenth of programmed current.
// - Termination needs feedback above recharge level and current below one tenth.
// - A 5 hour safety timer bounds fast charge.
// - Recharge drop, power-on reset or enable toggle restarts cycle and timer.
// - Sleep when sense_neg exceeds supply; wake when supply exceeds it.
// - Supply under lockout holds everything disabled.
// - Charge enabled only when every qualifying condition holds, after 30ms.
// - Any fault condition stops charge; overtemp has hysteresis from comparator.
// - Fast charge entry ramps target in 8 steps of 1.6ms.
// - Zero and full-on duty allowed, high side limited to 99.5 percent.
// - Bootstrap low over three cycles forces a low-side refresh.
// - Synchronous complementary drive while sense above 5mV.
// - 30ns dead time between high and low conduction.
// - Non-synchronous below 5mV, forced below 2V battery or 1.25mV average.
// - Discontinuous mode gives one 80ns low-side refresh pulse per cycle; here only in cycles where bootstrap is seen low or a refresh is forced.
// - Zero duty keeps high side off, low side only refresh pulse.
// - Enable falling edge resets timers and clears latched faults.
// - Overtemperature pauses the safety timer instead of resetting it.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "charge_cycle_map.vh"
module charge_cycle_sequencer #(
  parameter [27:0] PRE_TIMEOUT = `PRE_TIMEOUT_TICKS,
  parameter [27:0] FAST_TIMEOUT = `FAST_TIMEOUT_TICKS,
  parameter [15:0] TICK_DIV = `TICK_CYCLES,
  parameter [15:0] STARTUP = `STARTUP_TICKS
) (
  input wire sys_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire charge_enable,
  input wire supply_uvlo,
  input wire supply_low_state,
  input wire sleep_cmp,
  input wire input_overvoltage,
  input wire ldo_ok,
  input wire die_overtemp,
  input wire battery_temp_fault,
  input wire below_low_batt,
  input wire below_recharge,
  input wire above_recharge_fb,
  input wire current_below_term,
  input wire sense_above_sync,
  input wire battery_below_2v,
  input wire sense_avg_low,
  input wire boot_low,
  input wire [6:0] pwm_duty,
  output wire high_drive,
  output wire low_drive,
  output reg charging,
  output reg fault,
  output reg power_good,
  output reg done,
  output reg [7:0] current_target
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_PRE = 3'd1;
  localparam [2:0] ST_SOFT = 3'd2;
  localparam [2:0] ST_FAST = 3'd3;
  localparam [2:0] ST_DONE = 3'd4;
  localparam [2:0] ST_FAULT = 3'd5;
  localparam integer NSYNC = 14;
  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a change counts once stages two and three agree.
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] s1;
  reg [NSYNC-1:0] s2;
  reg [NSYNC-1:0] s3;
  reg [NSYNC-1:0] clean;
  assign raw_in = {boot_low, sense_avg_low, battery_below_2v, sense_above_sync,
    current_below_term, above_recharge_fb, below_recharge, below_low_batt,
    battery_temp_fault, die_overtemp, ldo_ok, input_overvoltage, sleep_cmp,
    charge_enable};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          clean[gi] <= 1'b0;
        end
        else
        begin
          s1[gi] <= raw_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi])
            clean[gi] <= s3[gi];
        end
      end
    end
  endgenerate
  // The two supply comparators are synchronised separately; supply_uvlo feeds the lockout, supply_low_state the qualification.
  reg [2:0] uv_s;
  reg [2:0] lo_s;
  reg uvlo;
  reg vlow;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      uv_s <= 3'h7;
      lo_s <= 3'h7;
      uvlo <= 1'b1;
      vlow <= 1'b1;
    end
    else
    begin
      uv_s <= {uv_s[1:0], supply_uvlo};
      lo_s <= {lo_s[1:0], supply_low_state};
      if (uv_s[1] == uv_s[2])
        uvlo <= uv_s[2];
      if (lo_s[1] == lo_s[2])
        vlow <= lo_s[2];
    end
  end
  wire en = clean[0];
  wire sleeping = clean[1];
  wire ovp = clean[2];
  wire ldo_good = clean[3];
  wire hot = clean[4];
  wire ts_bad = clean[5];
  wire low_batt = clean[6];
  wire rech_low = clean[7];
  wire fb_high = clean[8];
  wire i_low = clean[9];
  wire sense_ok = clean[10];
  wire bat2v = clean[11];
  wire avg_low = clean[12];
  wire boot_q = clean[13];
  ////////////////////////////////////////////////////////////////////////////
  // APB registers: control word plus status readback.
  reg [31:0] ctrl;
  reg [2:0] state;
  wire wr = psel && penable && pwrite;
  wire sw_restart = wr && paddr == `REG_CTRL && pwdata[1];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == `REG_CTRL || paddr == `REG_STATUS ||
    paddr == `REG_DUTY || paddr == `REG_SETPOINT);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ctrl <= `CTRL_RESET;
    else if (wr && paddr == `REG_CTRL)
      ctrl <= {30'h0, 1'b0, pwdata[0]};
  end
  // Read data is registered so it changes only after the setup cycle.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `REG_CTRL: prdata <= ctrl;
        `REG_STATUS: prdata <= {22'h0, state, done, fault, charging, power_good,
          sleeping, uvlo, hot};
        `REG_DUTY: prdata <= {25'h0, pwm_duty};
        `REG_SETPOINT: prdata <= {24'h0, current_target};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: one 100us tick pulse drives every slow timer.
  reg [15:0] div;
  reg tick;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div <= 16'h0000;
      tick <= 1'b0;
    end
    else if (div == TICK_DIV - 16'h0001)
    begin
      div <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      div <= div + 16'h0001;
      tick <= 1'b0;
    end
  end
  // Startup delay after power-up; lockout restarts it.
  reg [15:0] startup;
  wire started = (startup == STARTUP);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      startup <= 16'h0000;
    else if (uvlo)
      startup <= 16'h0000;
    else if (tick && !started)
      startup <= startup + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Qualification and restart events.
  reg en_d;
  reg rech_d;
  wire en_fall = en_d && !en;
  wire en_rise = !en_d && en;
  wire rech_fall = !rech_d && rech_low;
  wire qualified = en && !vlow && !uvlo && !sleeping && !ovp && started && ldo_good &&
    !hot && !ts_bad;
  wire restart = en_rise || en_fall || sw_restart || (rech_fall && state == ST_DONE);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_d <= 1'b0;
      rech_d <= 1'b0;
    end
    else
    begin
      en_d <= en;
      rech_d <= rech_low;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Charge state machine with safety timer and soft-start stepping.
  reg [27:0] timer;
  reg [3:0] step;
  reg [7:0] step_ticks;
  wire [7:0] current_set_input = ctrl[0] ? 8'hFF : 8'hC8;
  // The ramp product is kept wide so the upper steps do not wrap.
  wire [11:0] ramp = {4'h0, current_set_input} * {8'h00, step};
  localparam integer STEP_LAST_I = `SOFT_STEP_TICKS - 1;
  localparam [7:0] STEP_LAST = STEP_LAST_I[7:0];
  reg [2:0] next_state;
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (qualified) next_state = low_batt ? ST_PRE : ST_SOFT;
      ST_PRE:
        if (!low_batt) next_state = ST_SOFT;
        else if (timer >= PRE_TIMEOUT) next_state = ST_FAULT;
      ST_SOFT:
        if (timer >= FAST_TIMEOUT) next_state = ST_FAULT;
        else if (step == `SOFT_STEPS) next_state = ST_FAST;
      ST_FAST:
        if (timer >= FAST_TIMEOUT) next_state = ST_FAULT;
        else if (fb_high && i_low) next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
      ST_FAULT: next_state = ST_FAULT;
      default: next_state = ST_IDLE;
    endcase
    // Losing any qualifier stops charge; the cycle resumes from idle.
    if (!qualified && state != ST_FAULT && state != ST_DONE)
      next_state = ST_IDLE;
    if (restart || uvlo)
      next_state = ST_IDLE;
  end
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      timer <= 28'h0000000;
      step <= 4'h0;
      step_ticks <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (restart || uvlo || (state == ST_PRE && next_state == ST_SOFT))
        timer <= 28'h0000000;
      else if (tick && !hot && (state == ST_PRE || state == ST_SOFT || state == ST_FAST))
        timer <= timer + 28'h0000001;
      // Each entry to the ramp starts again from the first step.
      if (next_state == ST_SOFT && state != ST_SOFT)
      begin
        step <= 4'h1;
        step_ticks <= 8'h00;
      end
      else if (state == ST_SOFT && tick)
      begin
        if (step_ticks == STEP_LAST)
        begin
          step_ticks <= 8'h00;
          step <= step + 4'h1;
        end
        else
          step_ticks <= step_ticks + 8'h01;
      end
    end
  end
  // Outputs; the setpoint is a fraction of the programmed current.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      charging <= 1'b0;
      fault <= 1'b0;
      done <= 1'b0;
      power_good <= 1'b0;
      current_target <= 8'h00;
    end
    else
    begin
      charging <= (state == ST_PRE || state == ST_SOFT || state == ST_FAST);
      fault <= (state == ST_FAULT);
      done <= (state == ST_DONE);
      power_good <= !uvlo && !ovp && !sleeping;
      case (state)
        ST_PRE: current_target <= current_set_input / 8'd10;
        ST_SOFT: current_target <= ramp[10:3];
        ST_FAST: current_target <= current_set_input;
        default: current_target <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Mode choice feeds the gate drive.
  wire sync_mode = sense_ok && !bat2v && !avg_low;
  gate_drive u_gate (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(charging),
    .duty(pwm_duty),
    .sync_mode(sync_mode),
    .boot_low(boot_q),
    .high_drive(high_drive),
    .low_drive(low_drive)
  );
endmodule // charge_cycle_sequencer
`default_nettype wire

// ### dv/power_stage_model.sv
// Behavioural power stage: bootstrap capacitor and current sense comparators.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic high_drive,
  input wire logic low_drive,
  input wire logic heavy_load,
  output logic boot_low,
  output logic sense_above_sync,
  output logic battery_below_2v,
  output logic sense_avg_low
);
  logic [7:0] boot_level;
  // Low side conduction tops the bootstrap up; leakage drains it, so refresh is really needed.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      boot_level <= 8'h00;
    else if (low_drive)
      boot_level <= 8'h40;
    else if (boot_level != 8'h00)
      boot_level <= boot_level - 8'h01;
  end
  // Sense comparators follow the load that the bench commands.
  assign boot_low = (boot_level < 8'h08);
  assign sense_above_sync = heavy_load;
  assign sense_avg_low = !heavy_load;
  assign battery_below_2v = 1'b0;
endmodule // power_stage_model
`default_nettype wire

// ### dv/charge_cycle_sequencer_asserts.sv
// Checker for gate drive and charge qualification outputs of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic charge_enable,
  input wire logic supply_uvlo,
  input wire logic sleep_cmp,
  input wire logic sense_above_sync,
  input wire logic [6:0] pwm_duty,
  input wire logic high_drive,
  input wire logic low_drive,
  input wire logic charging,
  input wire logic fault,
  input wire logic power_good
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] high_run;
  logic [7:0] zero_run;
  // Run lengths of high side conduction and of a zero duty request.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_run <= 8'h00;
      zero_run <= 8'h00;
    end
    else
    begin
      high_run <= high_drive ? high_run + 8'h01 : 8'h00;
      zero_run <= (pwm_duty != 7'h00) ? 8'h00 : ((zero_run == 8'hFF) ? zero_run : zero_run + 8'h01);
    end
  end
  property p_no_overlap; !(high_drive && low_drive); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
  property p_dead_hl; $fell(high_drive) |-> !low_drive [*4]; endproperty
  a_dead_hl: assert property (p_dead_hl) else $error("short dead time after high");
  property p_dead_lh; $fell(low_drive) |-> !high_drive [*4]; endproperty
  a_dead_lh: assert property (p_dead_lh) else $error("short dead time after low");
  property p_duty_max; high_run <= 8'h67; endproperty
  a_duty_max: assert property (p_duty_max) else $error("high side on too long");
  property p_zero_duty; (zero_run >= 8'hD0) |-> !high_drive; endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("high side on at zero duty");
  property p_refresh;
    $rose(low_drive) && !sense_above_sync && !$past(sense_above_sync, 8) |-> ##[1:11] !low_drive;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh pulse too long");
  property p_enable_off; !charge_enable [*8] |-> !charging; endproperty
  a_enable_off: assert property (p_enable_off) else $error("charging while disabled");
  property p_uvlo; supply_uvlo [*8] |-> !charging && !high_drive && !low_drive && !power_good;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("active under lockout");
  property p_sleep; sleep_cmp [*8] |-> !charging && !power_good; endproperty
  a_sleep: assert property (p_sleep) else $error("active in sleep");
  property p_fault_off; fault |-> !charging; endproperty
  a_fault_off: assert property (p_fault_off) else $error("charging with fault");
endmodule // charge_cycle_sequencer_asserts
bind charge_cycle_sequencer charge_cycle_sequencer_asserts u_charge_cycle_sequencer_asserts (
  .sys_clk(sys_clk), .resetn(resetn), .charge_enable(charge_enable),
  .supply_uvlo(supply_uvlo), .sleep_cmp(sleep_cmp), .sense_above_sync(sense_above_sync),
  .pwm_duty(pwm_duty), .high_drive(high_drive), .low_drive(low_drive),
  .charging(charging), .fault(fault), .power_good(power_good));
`default_nettype wire

// ### dv/charge_cycle_sequencer_bench.sv
// Self-checking bench for the charge cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "charge_cycle_map.vh"
module charge_cycle_sequencer_bench;
  localparam int ST_CHG = 1;
  localparam int ST_FLT = 2;
  localparam int ST_DONE = 3;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, current_target, prev;
  logic [31:0] pwdata, prdata, rd;
  logic charge_enable, supply_uvlo, supply_low_state, sleep_cmp, input_overvoltage, ldo_ok;
  logic die_overtemp, battery_temp_fault, below_low_batt, below_recharge, above_recharge_fb;
  logic current_below_term, sense_above_sync, battery_below_2v, sense_avg_low, boot_low;
  logic heavy_load, high_drive, low_drive, charging, fault, power_good, done;
  logic [6:0] pwm_duty;
  logic [3:0] st;
  int failures = 0, tests_run = 0, cycles = 0, hi_cnt = 0, hi_mark;
  assign st = {done, fault, charging, power_good};
  // Short counts keep every timer reachable within the run.
  charge_cycle_sequencer #(.PRE_TIMEOUT(28'h14), .FAST_TIMEOUT(28'h3E8), .TICK_DIV(16'h4),
    .STARTUP(16'h3)) u_charge_cycle_sequencer (.sys_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .charge_enable, .supply_uvlo,
    .supply_low_state, .sleep_cmp, .input_overvoltage, .ldo_ok, .die_overtemp,
    .battery_temp_fault, .below_low_batt, .below_recharge, .above_recharge_fb,
    .current_below_term, .sense_above_sync, .battery_below_2v, .sense_avg_low, .boot_low,
    .pwm_duty, .high_drive, .low_drive, .charging, .fault, .power_good, .done, .current_target);
  power_stage_model u_power_stage_model (.sys_clk, .resetn, .high_drive, .low_drive,
    .heavy_load, .boot_low, .sense_above_sync, .battery_below_2v, .sense_avg_low);
  ////////////////////////////////////////////////////////////////////////////////
  // Free running clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Cycle count for the hang limit and a count of high side cycles.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    hi_cnt <= hi_cnt + (high_drive ? 1 : 0);
    if (cycles == 20000)
    begin
      failures = failures + 1;
      end_sim();
    end
  end
  task end_sim();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high at an edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_st(input int k, input logic v, input int lim);
    repeat (lim)
    begin
      @(posedge sys_clk);
      if (st[k] === v)
        break;
    end
    chk(st[k], v);
  endtask
  task setf(input int i, input logic on);
    case (i)
      0: supply_low_state <= on;
      1: sleep_cmp <= on;
      2: input_overvoltage <= on;
      3: ldo_ok <= !on;
      4: die_overtemp <= on;
      5: battery_temp_fault <= on;
      6: supply_uvlo <= on;
      default: charge_enable <= !on;
    endcase
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {charge_enable, supply_uvlo, supply_low_state, sleep_cmp, input_overvoltage} = 5'h00;
    {ldo_ok, die_overtemp, battery_temp_fault, below_low_batt, below_recharge} = 5'h12;
    {above_recharge_fb, current_below_term, heavy_load, pwm_duty} = 10'h000;
    repeat (10) @(posedge sys_clk);
    chk({charging, fault, done, current_target}, 32'h0);
    resetn <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `REG_CTRL, 32'h0);
    // Precharge, its timeout and the clear on enable falling.
    charge_enable <= 1'b1;
    wait_st(ST_CHG, 1'b1, 200);
    repeat (8) @(posedge sys_clk);
    chk(current_target, 32'h14);
    wait_st(ST_FLT, 1'b1, 200);
    chk(charging, 32'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h2A8);
    apb(1'b1, `REG_CTRL, 32'h2);
    wait_st(ST_FLT, 1'b0, 40);
    wait_st(ST_FLT, 1'b1, 200);
    charge_enable <= 1'b0;
    wait_st(ST_FLT, 1'b0, 40);
    charge_enable <= 1'b1;
    wait_st(ST_CHG, 1'b1, 200);
    below_low_batt <= 1'b0;
    prev = 8'h14;
    // Soft start walks the target up in eighths of the setpoint.
    for (int k = 1; k <= 8; k++)
    begin
      repeat (200)
      begin
        @(posedge sys_clk);
        if (current_target !== prev)
          break;
      end
      prev = current_target;
      chk(prev, 32'h19 * k);
    end
    apb(1'b0, `REG_SETPOINT, 32'h0);
    chk(rd, 32'hC8);
    // Gate drive in synchronous, full-on, non-synchronous and zero duty operation.
    heavy_load <= 1'b1;
    pwm_duty <= 7'h34;
    repeat (400) @(posedge sys_clk);
    pwm_duty <= 7'h7F;
    repeat (400) @(posedge sys_clk);
    heavy_load <= 1'b0;
    pwm_duty <= 7'h34;
    repeat (400) @(posedge sys_clk);
    pwm_duty <= 7'h00;
    repeat (120) @(posedge sys_clk);
    hi_mark = hi_cnt;
    repeat (208) @(posedge sys_clk);
    chk(hi_cnt - hi_mark, 32'h0);
    // Termination, then recharge restarts the cycle.
    above_recharge_fb <= 1'b1;
    current_below_term <= 1'b1;
    wait_st(ST_DONE, 1'b1, 100);
    chk(charging, 32'h0);
    {below_recharge, above_recharge_fb, current_below_term} <= 3'h4;
    wait_st(ST_DONE, 1'b0, 100);
    wait_st(ST_CHG, 1'b1, 200);
    below_recharge <= 1'b0;
    // Every stop condition halts charge; clearing it lets charge resume.
    for (int i = 0; i < 8; i++)
    begin
      setf(i, 1'b1);
      wait_st(ST_CHG, 1'b0, 100);
      setf(i, 1'b0);
      wait_st(ST_CHG, 1'b1, 400);
    end
    // The enable toggle above restarted the safety timer.
    repeat (3850) @(posedge sys_clk);
    chk(fault, 32'h0);
    wait_st(ST_FLT, 1'b1, 400);
    end_sim();
  end
endmodule // charge_cycle_sequencer_bench
`default_nettype wire
